// file: rtl/pmh_defs.svh
/*
  power mode host constants.
  assumes inclusion by bare name.
*/
`ifndef PMH_DEFS_SVH
`define PMH_DEFS_SVH

// ==========================================================
// own registers, byte addresses on the software apb
`define PMH_OFF_CTRL        12'h000
`define PMH_OFF_CMD         12'h004
`define PMH_OFF_STATUS      12'h008
`define PMH_OFF_WAKE        12'h00C

// ctrl fields
`define PMH_CTRL_SLEEP      0
`define PMH_CTRL_PDOWN      1
`define PMH_CTRL_FAST       2
`define PMH_CTRL_LXT_KEEP   3
`define PMH_CTRL_LOW_SPEED_RC_OSC_KEEP  4
`define PMH_CTRL_RST        5'h00

// cmd codes in cmd[2:0], clear mask in cmd[15:8]
`define PMH_CMD_READ_CAUSE  3'h1
`define PMH_CMD_CLR_CAUSE   3'h2
`define PMH_CMD_TRIM        3'h3
`define PMH_CMD_SLEEP       3'h4

// status fields
`define PMH_ST_BUSY         0
`define PMH_ST_BLOCKED      1
`define PMH_ST_LOCKED       2
`define PMH_ST_ASLEEP       3
`define PMH_ST_REFUSED      4
`define PMH_ST_LATE         5

// ==========================================================
// device registers, reached through the device port
`define PMH_DEV_BASE        32'h0000_0000
`define PMH_DEV_CAUSE       32'h0000_0004
`define PMH_DEV_TRIM_CTRL   32'h0000_0080
`define PMH_DEV_TRIM_STAT   32'h0000_0088
// target select 10, calc loop 11, retry limit 11
`define PMH_TRIM_VALUE      32'h0000_00F2
`define PMH_TRIM_LOCK_BIT   0
`define PMH_CAUSE_MASK      8'hB7

// ==========================================================
// timing
`define PMH_CLK_PERIOD_NS   100
`define PMH_WAKE_MAX_NS     6000
`define PMH_CTS_TICKS       2
`define PMH_RTC_TICKS       1

`endif

// file: rtl/pmh_pkg.sv
/*
  power mode host types.
  assumes nothing.
*/
package pmh_pkg;

  // ==========================================================
  // sequencer states
  typedef enum logic [6:0] {
    PMH_IDLE  = 7'h01,
    PMH_RDC   = 7'h02,
    PMH_CLR   = 7'h04,
    PMH_TRW   = 7'h08,
    PMH_TRP   = 7'h10,
    PMH_SLP   = 7'h20,
    PMH_DOWN  = 7'h40
  } pmh_state_t;

  // ==========================================================
  // wake source bit positions
  typedef enum int {
    PMH_SRC_RTC  = 0,
    PMH_SRC_WDT  = 1,
    PMH_SRC_I2C  = 2,
    PMH_SRC_TMR  = 3,
    PMH_SRC_UART = 4,
    PMH_SRC_SPI  = 5,
    PMH_SRC_BOD  = 6,
    PMH_SRC_PIN  = 7
  } pmh_src_t;

endpackage

// file: rtl/pmh_apb_master.sv
/*
  apb master to the device, one transfer per request.
  assumes request steady until done.
*/
`timescale 1ns/100ps
`default_nettype none

module pmh_apb_master
  import pmh_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  output logic             done,
  output logic [31:0]      rdata,
  output logic [31:0]      m_paddr,
  output logic             m_psel,
  output logic             m_penable,
  output logic             m_pwrite,
  output logic [31:0]      m_pwdata,
  input  wire logic [31:0] m_prdata,
  input  wire logic        m_pready
);

  // ==========================================================
  // done is combinational so the caller leaves its state on the same edge
  assign done  = m_psel & m_penable & m_pready;
  assign rdata = m_prdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_psel    <= 1'b0;
      m_penable <= 1'b0;
      m_pwrite  <= 1'b0;
      m_paddr   <= 32'h0000_0000;
      m_pwdata  <= 32'h0000_0000;
    end else if (!m_psel) begin
      if (req) begin
        m_psel   <= 1'b1;
        m_pwrite <= wr;
        m_paddr  <= addr;
        m_pwdata <= wdata;
      end
    end else if (!m_penable) begin
      m_penable <= 1'b1;
    end else if (m_pready) begin
      m_psel    <= 1'b0;
      m_penable <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: rtl/pmh_reentry_guard.sv
/*
  holds power-down back until each waking source allows it.
  assumes one-cycle pulses on pclk.
*/
`timescale 1ns/100ps
`default_nettype none

`include "pmh_defs.svh"

module pmh_reentry_guard
  import pmh_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       arm,
  input  wire logic [7:0] src,
  input  wire logic       uart_cts_wake,
  input  wire logic       rtc_kernel_tick,
  input  wire logic       uart_kernel_tick,
  input  wire logic       spi_slave_clock,
  input  wire logic       timer_flag_cleared,
  input  wire logic       pin_flag_cleared,
  input  wire logic       supply_above_target,
  input  wire logic       brownout_interrupt_enable,
  output logic            blocked,
  output logic [7:0]      pending
);

  // ==========================================================
  logic [7:0] pend_r;
  logic [7:0] pend_nxt;
  logic [7:0] done_w;
  logic [7:0] set_w;
  logic [1:0] cts_cnt_r;
  logic [1:0] rtc_cnt_r;
  logic       cts_r;
  logic       sclk_r;
  logic       sclk_fall;

  assign sclk_fall = sclk_r & ~spi_slave_clock;
  // sources without a wait never become pending
  assign set_w = arm ? (src & ~(8'h01 << PMH_SRC_WDT) & ~(8'h01 << PMH_SRC_I2C)) : 8'h00;

  assign done_w[PMH_SRC_RTC]  = (rtc_cnt_r == 2'(`PMH_RTC_TICKS));
  assign done_w[PMH_SRC_WDT]  = 1'b1;
  assign done_w[PMH_SRC_I2C]  = 1'b1;
  assign done_w[PMH_SRC_TMR]  = timer_flag_cleared;
  assign done_w[PMH_SRC_UART] = ~cts_r | (cts_cnt_r == 2'(`PMH_CTS_TICKS));
  assign done_w[PMH_SRC_SPI]  = sclk_fall;
  assign done_w[PMH_SRC_BOD]  = supply_above_target | ~brownout_interrupt_enable;
  assign done_w[PMH_SRC_PIN]  = pin_flag_cleared;

  // a fresh wake beats a clear seen in the same cycle
  assign pend_nxt = set_w | (pend_r & ~done_w);
  assign blocked  = |pend_r;
  assign pending  = pend_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 8'h00;
      sclk_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
      sclk_r <= spi_slave_clock;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_r     <= 1'b0;
      cts_cnt_r <= 2'h0;
      rtc_cnt_r <= 2'h0;
    end else if (arm) begin
      cts_r     <= uart_cts_wake;
      cts_cnt_r <= 2'h0;
      rtc_cnt_r <= 2'h0;
    end else begin
      if (uart_kernel_tick && cts_cnt_r != 2'(`PMH_CTS_TICKS)) begin
        cts_cnt_r <= cts_cnt_r + 2'h1;
      end
      if (rtc_kernel_tick && rtc_cnt_r != 2'(`PMH_RTC_TICKS)) begin
        rtc_cnt_r <= rtc_cnt_r + 2'h1;
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/pmh_top.sv
/*
  power mode host: sleep, power-down
  and wfi pins, wake forwarding,
  reset cause and trim via device port.
  assumes apb from software, apb to
  the device, all on pclk.
*/
// Added by the designer: register access over APB and the address map.
// How it works
// - sleep enable plus wfi enters idle
// - power-down needs sleep, pd enable, wfi
// - pin wake: clear pin flag first
// - cts wake: wait two uart clocks
// - rtc wake: wait one rtc clock
// - spi wake: wait for slave clock fall
// - timer wake: clear flag or soft reset; the guard releases on timer_flag_cleared only
// - brownout wake: supply ok or interrupt off
// - pick 1.8V above 12MHz, else 1.6V
// - set trim loop and retry to 11
`timescale 1ns/100ps
`default_nettype none

`include "pmh_defs.svh"

module pmh_top
  import pmh_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] s_paddr,
  input  wire logic        s_psel,
  input  wire logic        s_penable,
  input  wire logic        s_pwrite,
  input  wire logic [31:0] s_pwdata,
  output logic [31:0]      s_prdata,
  output logic             s_pready,
  output logic             s_pslverr,
  output logic [31:0]      m_paddr,
  output logic             m_psel,
  output logic             m_penable,
  output logic             m_pwrite,
  output logic [31:0]      m_pwdata,
  input  wire logic [31:0] m_prdata,
  input  wire logic        m_pready,
  output logic             sleep_enable,
  output logic             power_down_enable,
  output logic             wait_for_interrupt,
  output logic             ldo_high_select,
  output logic             low_speed_crystal_keep,
  output logic             low_speed_rc_osc_keep,
  output logic [7:0]       wake_request,
  input  wire logic        cpu_clock_running,
  input  wire logic [7:0]  wake_event,
  input  wire logic        uart_cts_wake,
  input  wire logic        rtc_kernel_tick,
  input  wire logic        uart_kernel_tick,
  input  wire logic        spi_slave_clock,
  input  wire logic        timer_flag_cleared,
  input  wire logic        pin_flag_cleared,
  input  wire logic        supply_above_target,
  input  wire logic        brownout_interrupt_enable
);

  localparam int WAKE_CYC = `PMH_WAKE_MAX_NS / `PMH_CLK_PERIOD_NS;

  // ==========================================================
  // state
  pmh_state_t  state_r;
  pmh_state_t  state_nxt;
  logic [4:0]  ctrl_r;
  logic [7:0]  mask_r;
  logic [7:0]  cause_r;
  logic [7:0]  wake_seen_r;
  logic        locked_r;
  logic        refused_r;
  logic        late_r;
  logic        pd_entry_r;
  logic        wfi_r;
  logic [6:0]  lat_cnt_r;
  logic        lat_run_r;
  logic        ready_r;
  logic [31:0] rdata_r;
  logic        slverr_r;

  // ==========================================================
  // software apb decode
  wire         setup_w   = s_psel & ~s_penable;
  wire         access_w  = s_psel & s_penable & ready_r;
  wire         wr_w      = access_w & s_pwrite;
  wire         hit_ctrl  = (s_paddr == `PMH_OFF_CTRL);
  wire         hit_cmd   = (s_paddr == `PMH_OFF_CMD);
  wire         hit_stat  = (s_paddr == `PMH_OFF_STATUS);
  wire         hit_wake  = (s_paddr == `PMH_OFF_WAKE);
  wire         mapped_w  = hit_ctrl | hit_cmd | hit_stat | hit_wake;
  wire         cmd_wr    = wr_w & hit_cmd;
  wire [2:0]   cmd_code  = s_pwdata[2:0];
  wire         idle_w    = (state_r == PMH_IDLE);
  wire         guard_blk;
  wire [7:0]   guard_pend;
  // a power-down request is held back while any waking source still forbids it
  wire         pd_req_w  = ctrl_r[`PMH_CTRL_SLEEP] & ctrl_r[`PMH_CTRL_PDOWN];
  wire         sleep_ok  = ctrl_r[`PMH_CTRL_SLEEP] & ~(pd_req_w & guard_blk);
  wire         cmd_take  = cmd_wr & idle_w & (cmd_code != `PMH_CMD_SLEEP | sleep_ok);
  wire         cmd_bad   = cmd_wr & ~cmd_take;

  wire [31:0]  status_w  = {16'h0000, cause_r, 2'b00,
                            late_r, refused_r, (state_r == PMH_DOWN),
                            locked_r, guard_blk, ~idle_w};
  wire [31:0]  rd_mux    = hit_ctrl ? {27'h0, ctrl_r} :
                           hit_stat ? status_w :
                           hit_wake ? {16'h0000, guard_pend, wake_seen_r} :
                           32'h0000_0000;

  // ==========================================================
  // device port request
  wire         m_done;
  wire [31:0]  m_rdata;
  wire         m_req   = (state_r == PMH_RDC) | (state_r == PMH_CLR) |
                         (state_r == PMH_TRW) | (state_r == PMH_TRP);
  wire         m_wr    = (state_r == PMH_CLR) | (state_r == PMH_TRW);
  wire [31:0]  m_addr  = (state_r == PMH_TRW) ? `PMH_DEV_BASE + `PMH_DEV_TRIM_CTRL :
                         (state_r == PMH_TRP) ? `PMH_DEV_BASE + `PMH_DEV_TRIM_STAT :
                         `PMH_DEV_BASE + `PMH_DEV_CAUSE;
  wire [31:0]  m_wdat  = (state_r == PMH_TRW) ? `PMH_TRIM_VALUE :
                         {24'h00_0000, mask_r};
  wire         lock_w  = m_rdata[`PMH_TRIM_LOCK_BIT];

  pmh_apb_master u_master (
    .pclk      (pclk),
    .presetn   (presetn),
    .req       (m_req),
    .wr        (m_wr),
    .addr      (m_addr),
    .wdata     (m_wdat),
    .done      (m_done),
    .rdata     (m_rdata),
    .m_paddr   (m_paddr),
    .m_psel    (m_psel),
    .m_penable (m_penable),
    .m_pwrite  (m_pwrite),
    .m_pwdata  (m_pwdata),
    .m_prdata  (m_prdata),
    .m_pready  (m_pready)
  );

  // ==========================================================
  // re-entry guard, armed as the core clock returns after power-down
  wire         wake_back = (state_r == PMH_DOWN) & cpu_clock_running;
  wire         arm_w     = wake_back & pd_entry_r;

  pmh_reentry_guard u_guard (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .arm                       (arm_w),
    .src                       (wake_seen_r | wake_event),
    .uart_cts_wake             (uart_cts_wake),
    .rtc_kernel_tick           (rtc_kernel_tick),
    .uart_kernel_tick          (uart_kernel_tick),
    .spi_slave_clock           (spi_slave_clock),
    .timer_flag_cleared        (timer_flag_cleared),
    .pin_flag_cleared          (pin_flag_cleared),
    .supply_above_target       (supply_above_target),
    .brownout_interrupt_enable (brownout_interrupt_enable),
    .blocked                   (guard_blk),
    .pending                   (guard_pend)
  );

  // ==========================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PMH_IDLE: begin
        if (cmd_take) begin
          unique case (cmd_code)
            `PMH_CMD_READ_CAUSE: state_nxt = PMH_RDC;
            `PMH_CMD_CLR_CAUSE:  state_nxt = PMH_CLR;
            `PMH_CMD_TRIM:       state_nxt = PMH_TRW;
            `PMH_CMD_SLEEP:      state_nxt = PMH_SLP;
            default:             state_nxt = PMH_IDLE;
          endcase
        end
      end
      PMH_RDC: if (m_done) state_nxt = PMH_IDLE;
      PMH_CLR: if (m_done) state_nxt = PMH_RDC;
      PMH_TRW: if (m_done) state_nxt = PMH_TRP;
      PMH_TRP: if (m_done && lock_w) state_nxt = PMH_IDLE;
      // core clock must stop before the host counts the core as asleep
      PMH_SLP: if (!cpu_clock_running) state_nxt = PMH_DOWN;
      PMH_DOWN: if (cpu_clock_running) state_nxt = PMH_IDLE;
      default: state_nxt = PMH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PMH_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `PMH_CTRL_RST;
      mask_r    <= 8'h00;
      refused_r <= 1'b0;
    end else begin
      if (wr_w && hit_ctrl) begin
        ctrl_r <= s_pwdata[4:0];
      end
      if (cmd_take && cmd_code == `PMH_CMD_CLR_CAUSE) begin
        mask_r <= s_pwdata[15:8] & `PMH_CAUSE_MASK;
      end
      // refusal is sticky; a status write of one clears it unless a new one lands
      if (cmd_bad) begin
        refused_r <= 1'b1;
      end else if (wr_w && hit_stat && s_pwdata[`PMH_ST_REFUSED]) begin
        refused_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r  <= 8'h00;
      locked_r <= 1'b0;
    end else begin
      if (state_r == PMH_RDC && m_done) begin
        cause_r <= m_rdata[7:0] & `PMH_CAUSE_MASK;
      end
      if (state_r == PMH_TRW) begin
        locked_r <= 1'b0;
      end else if (state_r == PMH_TRP && m_done) begin
        locked_r <= lock_w;
      end
    end
  end

  // ==========================================================
  // pins toward the power manager
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_enable           <= 1'b0;
      power_down_enable      <= 1'b0;
      wfi_r                  <= 1'b0;
      ldo_high_select        <= 1'b0;
      low_speed_crystal_keep <= 1'b0;
      low_speed_rc_osc_keep  <= 1'b0;
      wake_request           <= 8'h00;
      pd_entry_r             <= 1'b0;
    end else begin
      sleep_enable      <= ctrl_r[`PMH_CTRL_SLEEP];
      power_down_enable <= pd_req_w & ~guard_blk;
      wfi_r             <= cmd_take && cmd_code == `PMH_CMD_SLEEP;
      ldo_high_select   <= ctrl_r[`PMH_CTRL_FAST];
      // settings hold through power-down; rtc and watchdog depend on them
      if (idle_w) begin
        low_speed_crystal_keep <= ctrl_r[`PMH_CTRL_LXT_KEEP];
        low_speed_rc_osc_keep  <= ctrl_r[`PMH_CTRL_LOW_SPEED_RC_OSC_KEEP];
      end
      wake_request <= wake_event;
      if (cmd_take && cmd_code == `PMH_CMD_SLEEP) begin
        pd_entry_r <= pd_req_w;
      end
    end
  end

  assign wait_for_interrupt = wfi_r;

  // ==========================================================
  // wake sources and wake latency while asleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_seen_r <= 8'h00;
      lat_cnt_r   <= 7'h00;
      lat_run_r   <= 1'b0;
      late_r      <= 1'b0;
    end else begin
      if (state_r == PMH_SLP) begin
        wake_seen_r <= 8'h00;
        lat_cnt_r   <= 7'h00;
        lat_run_r   <= 1'b0;
      end else if (state_r == PMH_DOWN && !cpu_clock_running) begin
        wake_seen_r <= wake_seen_r | wake_event;
        if (lat_run_r || |wake_event) begin
          lat_run_r <= 1'b1;
          if (lat_cnt_r != 7'h7F) begin
            lat_cnt_r <= lat_cnt_r + 7'h01;
          end
        end
      end
      // flag a core clock that returns from power-down later than the wake budget
      if (wake_back && pd_entry_r && lat_cnt_r > 7'(WAKE_CYC)) begin
        late_r <= 1'b1;
      end else if (wr_w && hit_stat && s_pwdata[`PMH_ST_LATE]) begin
        late_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // software apb answer: no wait state, error on unmapped offsets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r  <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else begin
      ready_r  <= setup_w;
      rdata_r  <= setup_w ? rd_mux : 32'h0000_0000;
      slverr_r <= setup_w & ~mapped_w;
    end
  end

  assign s_pready  = ready_r;
  assign s_prdata  = rdata_r;
  assign s_pslverr = slverr_r;

endmodule

`default_nettype wire

// file: dv/pmh_top_monitor.sv
/* checker for the power mode host pins and the device apb port.
   assumes it is bound into pmh_top, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// checker
module pmh_top_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] s_paddr,
  input wire logic        s_psel,
  input wire logic        s_penable,
  input wire logic        s_pwrite,
  input wire logic [31:0] s_pwdata,
  input wire logic        s_pready,
  input wire logic [31:0] m_paddr,
  input wire logic        m_psel,
  input wire logic        m_penable,
  input wire logic        m_pwrite,
  input wire logic [31:0] m_pwdata,
  input wire logic        m_pready,
  input wire logic        sleep_enable,
  input wire logic        power_down_enable,
  input wire logic        wait_for_interrupt,
  input wire logic        ldo_high_select,
  input wire logic [7:0]  wake_request,
  input wire logic [7:0]  wake_event
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic s_wr;
  assign s_wr = s_psel && s_penable && s_pready && s_pwrite;
  property p_rst;
    $rose(presetn) |-> !sleep_enable && !power_down_enable && wake_request == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_wfi;
    wait_for_interrupt |-> sleep_enable && $past(s_wr && s_paddr == 12'h004);
  endproperty
  a_wfi: assert property (p_wfi) else $error("wfi without sleep command");
  property p_pulse;
    wait_for_interrupt |=> !wait_for_interrupt;
  endproperty
  a_pulse: assert property (p_pulse) else $error("wfi longer than one cycle");
  property p_pd;
    power_down_enable |-> sleep_enable;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down without sleep");
  property p_wake;
    wake_request == $past(wake_event);
  endproperty
  a_wake: assert property (p_wake) else $error("wake not forwarded");
  property p_ldo;
    s_wr && s_paddr == 12'h000 && s_pwdata[2] |-> ##[1:2] ldo_high_select;
  endproperty
  a_ldo: assert property (p_ldo) else $error("high regulator not selected");
  property p_mrel;
    m_psel && m_penable && m_pready |=> !m_psel;
  endproperty
  a_mrel: assert property (p_mrel) else $error("device bus not released");
  property p_trim;
    m_psel && m_pwrite && m_paddr == 32'h0000_0080 |-> m_pwdata == 32'h0000_00F2;
  endproperty
  a_trim: assert property (p_trim) else $error("bad trim setting");
  property p_clr;
    m_psel && m_pwrite && m_paddr == 32'h0000_0004 |-> (m_pwdata & 32'hFFFF_FF48) == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear hits reserved cause bit");
endmodule
bind pmh_top pmh_top_monitor u_mon (.*);
`default_nettype wire

// file: dv/pmh_dev_model.sv
/* behavioural device: register port, power manager, trim.
   assumes the host drives it on pclk; slow stretches answers. */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// device model
module pmh_dev_model #(
  parameter logic [7:0] CAUSE0 = 8'hFF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic [31:0] m_paddr,
  input  wire logic        m_psel,
  input  wire logic        m_penable,
  input  wire logic        m_pwrite,
  input  wire logic [31:0] m_pwdata,
  output logic [31:0]      m_prdata,
  output logic             m_pready,
  input  wire logic        wait_for_interrupt,
  input  wire logic        power_down_enable,
  input  wire logic [7:0]  wake_request,
  output logic             cpu_clock_running
);
  logic [7:0] cause_r, dly_r;
  logic [4:0] trim_r;
  logic [1:0] wt_r;
  logic       pd_r, tg_r, acc, wr;
  assign acc = m_psel && m_penable;
  assign wr = acc && m_pready && m_pwrite;
  assign m_pready = acc && wt_r == 2'd0;
  // idle bus shows a toggling pattern, never the last word
  assign m_prdata = !acc ? {32{tg_r}} : m_paddr == 32'h4 ? {24'h0, cause_r}
                  : {31'h0, m_paddr == 32'h88 && trim_r == 5'd1};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r           <= CAUSE0;
      cpu_clock_running <= 1'b1;
      dly_r             <= 8'h00;
      trim_r            <= 5'h00;
      wt_r              <= 2'd0;
      pd_r              <= 1'b0;
      tg_r              <= 1'b0;
    end else begin
      tg_r <= ~tg_r;
      wt_r <= !acc ? {slow, slow} : (wt_r == 2'd0) ? 2'd0 : wt_r - 2'd1;
      if (wr && m_paddr == 32'h4) cause_r <= cause_r & ~m_pwdata[7:0];
      if (wr && m_paddr == 32'h80) trim_r <= {m_pwdata[1:0] == 2'b10, 4'h0};
      else if (trim_r > 5'd1) trim_r <= trim_r - 5'd1;
      if (wait_for_interrupt) begin
        cpu_clock_running <= 1'b0;
        pd_r              <= power_down_enable;
      end else if (dly_r > 8'd1) begin
        dly_r <= dly_r - 8'd1;
      end else if (dly_r == 8'd1 || !cpu_clock_running && wake_request != 8'h00 && !pd_r) begin
        dly_r             <= 8'h00;
        cpu_clock_running <= 1'b1;
      end else if (!cpu_clock_running && wake_request != 8'h00) begin
        dly_r <= slow ? 8'd70 : 8'd30;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/pmh_top_test.sv
/* self-checking bench for the power mode host.
   assumes the device model on the far apb port. */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// bench
module pmh_top_test;
  import pmh_pkg::*;
  typedef struct {logic [31:0] ex; logic [31:0] msk; logic ee;} pmh_exp_t;
  logic        pclk, presetn, s_psel, s_penable, s_pwrite, s_pready, s_pslverr, slow, b;
  logic        m_psel, m_penable, m_pwrite, m_pready, sleep_enable, power_down_enable;
  logic        wait_for_interrupt, ldo_high_select, low_speed_crystal_keep, cpu_clock_running;
  logic        low_speed_rc_osc_keep, uart_cts_wake, rtc_kernel_tick, uart_kernel_tick;
  logic        spi_slave_clock, timer_flag_cleared, pin_flag_cleared, supply_above_target;
  logic        brownout_interrupt_enable;
  logic [7:0]  wake_request, wake_event, cause;
  logic [11:0] s_paddr;
  logic [31:0] s_pwdata, s_prdata, m_paddr, m_pwdata, m_prdata, rv;
  int          fails, check_count, seed, n;
  pmh_exp_t    q[$];
  pmh_top uut (.*);
  pmh_dev_model dev (.*);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic conclude();
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  // answers are checked in order by the watcher below
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] ex, input logic [31:0] msk, input logic ee);
    q.push_back('{ex, msk, ee});
    @(posedge pclk);
    s_psel    <= 1'b1;
    s_penable <= 1'b0;
    s_pwrite  <= w;
    s_paddr   <= a;
    s_pwdata  <= d;
    @(posedge pclk);
    s_penable <= 1'b1;
    do @(posedge pclk); while (s_pready !== 1'b1);
    rv = s_prdata;
    s_psel    <= 1'b0;
    s_penable <= 1'b0;
  endtask
  always @(posedge pclk) begin
    if (s_psel && s_penable && s_pready === 1'b1 && q.size() > 0) begin
      cmp(s_prdata & q[0].msk, q[0].ex & q[0].msk);
      cmp1(s_pslverr, q[0].ee);
      void'(q.pop_front());
    end
  end
  task automatic waitb();
    do apb(1'b0, 12'h008, 32'h0, 32'h0, 32'h0, 1'b0); while (rv[0] !== 1'b0);
  endtask
  task automatic sw(input int s);
    apb(1'b1, 12'h004, 32'h4, 32'h0, 32'h0, 1'b0);
    while (cpu_clock_running !== 1'b0) @(posedge pclk);
    @(posedge pclk);
    wake_event[s] <= 1'b1;
    @(posedge pclk);
    wake_event <= 8'h00;
    while (cpu_clock_running !== 1'b1) @(posedge pclk);
    waitb();
  endtask
  task automatic rel(input int s);
    @(posedge pclk);
    case (s)
      0: rtc_kernel_tick <= 1'b1;
      3: timer_flag_cleared <= 1'b1;
      4: uart_kernel_tick <= 1'b1;
      5: spi_slave_clock <= 1'b0;
      6: supply_above_target <= 1'b1;
      default: pin_flag_cleared <= 1'b1;
    endcase
    @(posedge pclk);
    {rtc_kernel_tick, timer_flag_cleared, uart_kernel_tick, pin_flag_cleared} <= 4'h0;
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    #2000000;
    fails++;
    conclude();
  end
  initial begin
    {presetn, s_psel, s_penable, s_pwrite, slow, rtc_kernel_tick, uart_kernel_tick} = 7'h00;
    {timer_flag_cleared, pin_flag_cleared, supply_above_target} = 3'h0;
    {s_paddr, s_pwdata, wake_event} = 52'h0;
    {spi_slave_clock, uart_cts_wake, brownout_interrupt_enable} = 3'h7;
    seed = 43636;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp1(cpu_clock_running, 1'b1);
    apb(1'b0, 12'h000, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, 12'h004, 32'h1, 32'h0, 32'h0, 1'b0);
    waitb();
    cause = 8'hFF & 8'hB7;
    apb(1'b0, 12'h008, 32'h0, {16'h0, cause, 8'h0}, 32'hFF00, 1'b0);
    n = $random(seed);
    cause = cause & ~n[7:0];
    apb(1'b1, 12'h004, {16'h0, n[7:0], 8'h02}, 32'h0, 32'h0, 1'b0);
    waitb();
    apb(1'b0, 12'h008, 32'h0, {16'h0, cause, 8'h0}, 32'hFF00, 1'b0);
    slow <= 1'b1;
    apb(1'b1, 12'h004, 32'h3, 32'h0, 32'h0, 1'b0);
    waitb();
    apb(1'b0, 12'h008, 32'h0, 32'h4, 32'h4, 1'b0);
    apb(1'b1, 12'h000, 32'h1D, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h000, 32'h0, 32'h1D, 32'h1F, 1'b0);
    cmp1(low_speed_crystal_keep & low_speed_rc_osc_keep, 1'b1);
    n = $random(seed);
    sw(n & 7);
    cmp1(power_down_enable, 1'b0);
    apb(1'b1, 12'h000, 32'h1F, 32'h0, 32'h0, 1'b0);
    for (int s = 0; s < 8; s++) begin
      slow <= (s == 6);
      repeat (2) @(posedge pclk);
      cmp1(power_down_enable, 1'b1);
      sw(s);
      b = !(s == 1 || s == 2);
      apb(1'b0, 12'h008, 32'h0, {26'h0, s == 6, 3'h0, b, 1'b0}, 32'h23, 1'b0);
      if (b) begin
        apb(1'b1, 12'h004, 32'h4, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 12'h008, 32'h0, 32'h10, 32'h18, 1'b0);
        apb(1'b1, 12'h008, 32'h30, 32'h0, 32'h0, 1'b0);
        if (s == 4) rel(4);
        cmp1(power_down_enable, 1'b0);
        rel(s);
        cmp1(power_down_enable, 1'b1);
        spi_slave_clock     <= 1'b1;
        supply_above_target <= 1'b0;
      end
    end
    conclude();
  end
endmodule
`default_nettype wire
